// file: logic/cae_defs.svh
/*
 * Offsets, field positions, reset values and cycle counts for the
 * arithmetic/logic execution unit.
 * Assumes a 32-bit Avalon-MM slave with byte addresses.
 */
`ifndef CAE_DEFS_SVH
`define CAE_DEFS_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define CAE_ADDR_CMD 8'h00
`define CAE_ADDR_STATUS 8'h04
`define CAE_ADDR_SREG 8'h08
`define CAE_ADDR_PC 8'h0C
`define CAE_ADDR_SP 8'h10
`define CAE_ADDR_TOS 8'h14
`define CAE_ADDR_RF_BASE 8'h80

// ------------------------------------------------------------
// Command word fields
// ------------------------------------------------------------
`define CAE_CMD_IMM_LSB 0
`define CAE_CMD_SRC_LSB 8
`define CAE_CMD_DST_LSB 16
`define CAE_CMD_OP_LSB 24

// ------------------------------------------------------------
// Status flag positions and reset values
// ------------------------------------------------------------
`define CAE_FLG_C 0
`define CAE_FLG_Z 1
`define CAE_FLG_N 2
`define CAE_FLG_V 3
`define CAE_FLG_S 4
`define CAE_FLG_H 5
`define CAE_SREG_RST 8'h00
`define CAE_PC_RST 16'h0000

// ------------------------------------------------------------
// Register indices and cycle counts
// ------------------------------------------------------------
`define CAE_PTR_LO 5'h1E
`define CAE_PTR_HI 5'h1F
`define CAE_PROD_LO 5'h00
`define CAE_PROD_HI 5'h01
`define CAE_CYC_ALU 2'h1
`define CAE_CYC_WORD 2'h2
`define CAE_CYC_PROD 2'h2
`define CAE_CYC_JUMP 2'h2
`define CAE_CYC_CALL 2'h3

`endif

// file: logic/cae_pkg.sv
/*
 * Types of the arithmetic/logic execution unit.
 * Opcode values are set here; assumes cae_defs.svh supplies the other numeric constants.
 */
package cae_pkg;

   typedef enum logic [4:0] {
      CAE_OP_SUM = 5'h00, CAE_OP_SUM_CARRY = 5'h01,
      CAE_OP_WORD_PLUS_IMMEDIATE = 5'h02, CAE_OP_DIFF = 5'h03,
      CAE_OP_DIFFERENCE_IMMEDIATE = 5'h04, CAE_OP_DIFFERENCE_WITH_BORROW = 5'h05,
      CAE_OP_DIFFERENCE_IMMEDIATE_BORROW = 5'h06, CAE_OP_WORD_MINUS_IMMEDIATE = 5'h07,
      CAE_OP_CONJ = 5'h08, CAE_OP_CONJ_IMM = 5'h09, CAE_OP_DISJ = 5'h0A,
      CAE_OP_DISJ_IMM = 5'h0B, CAE_OP_EXCLUSIVE_DISJUNCTION = 5'h0C,
      CAE_OP_MASK_SET_BITS = 5'h0D, CAE_OP_MASK_CLEAR_BITS = 5'h0E,
      CAE_OP_PLUS_ONE = 5'h0F, CAE_OP_MINUS_ONE = 5'h10,
      CAE_OP_SELF_CHECK_FLAGS = 5'h11, CAE_OP_PRODUCT_UNSIGNED = 5'h12,
      CAE_OP_PRODUCT_SIGNED = 5'h13, CAE_OP_PRODUCT_MIXED_SIGN = 5'h14,
      CAE_OP_FRACTION_PRODUCT_UNSIGNED = 5'h15, CAE_OP_FRACTION_PRODUCT_SIGNED = 5'h16,
      CAE_OP_FRACTION_PRODUCT_MIXED = 5'h17, CAE_OP_POINTER_JUMP = 5'h18,
      CAE_OP_POINTER_CALL = 5'h19
   } cae_op_t;

   typedef struct packed {
      cae_op_t op;
      logic [4:0] dst;
      logic [4:0] src;
      logic [7:0] imm;
   } cae_cmd_t;

   typedef enum logic {
      CAE_ST_IDLE = 1'b0,
      CAE_ST_RUN = 1'b1
   } cae_state_t;

endpackage : cae_pkg

// file: logic/cae_exec.sv
/*
 * Execution unit for register arithmetic, logic, multiply and
 * indirect jump/call, with its own register file, status flags,
 * program counter and return stack, reached over Avalon-MM.
 * Assumes one clock and a master that holds each request until
 * it samples waitrequest low.
 */
// Decided for this implementation: the address map and the Avalon-MM interface to the registers.
// Notes on behaviour
// - Sum, with carry variant; Z,C,N,V,H; 1 cycle.
// - Difference, borrow variant; Z,C,N,V,H; 1 cycle.
// - Immediate difference, optional borrow; 1 cycle.
// - Word add/sub immediate on pair; 2 cycles.
// - AND/OR register or constant, XOR register only; Z,N,V only.
// - Mask set ORs, mask clear ANDs inverse.
// - Plus/minus one; Z,N,V; carry unchanged.
// - Self check ANDs register with itself.
// - Multiplies write product pair; Z,C; 2 cycles.
// - Fractional multiplies shift product left one.
// - Pointer jump loads PC from pointer pair.
// - Pointer call saves return, jumps; 3 cycles.
`timescale 1ns/100ps
`include "cae_defs.svh"

module cae_exec
   import cae_pkg::*;
#(
   parameter int STK_AW = 4
) (
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   input wire logic [7:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [7:0] rf_reg [32];
   logic [15:0] stk_reg [2**STK_AW];
   logic [7:0] sreg_reg;
   logic [15:0] pc_reg;
   logic [STK_AW-1:0] sp_reg;
   cae_state_t state_reg;
   logic [1:0] cnt_reg;
   cae_cmd_t ins_reg;
   logic wait_reg;
   logic [31:0] rdata_reg;

   // ------------------------------------------------------------
   // Bus slave
   // ------------------------------------------------------------
   logic accept;
   logic wr_fire;
   logic launch;
   logic commit;
   logic rf_hit;
   logic [4:0] rf_idx;
   logic [31:0] rd_mux;

   assign rf_hit = avs_address_in[7] && (avs_address_in[1:0] == 2'h0);
   assign rf_idx = avs_address_in[6:2];
   // Writes stall while an instruction runs so state is never torn
   assign accept = wait_reg && (avs_read_in || (avs_write_in && state_reg == CAE_ST_IDLE));
   assign wr_fire = avs_write_in && !wait_reg;
   assign launch = wr_fire && avs_address_in == `CAE_ADDR_CMD;
   assign commit = state_reg == CAE_ST_RUN && cnt_reg == 2'h1;

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (rf_hit) begin
         rd_mux = {24'h00_0000, rf_reg[rf_idx]};
      end else begin
         case (avs_address_in)
            `CAE_ADDR_STATUS: rd_mux = {29'h0000_0000, cnt_reg, state_reg};
            `CAE_ADDR_SREG: rd_mux = {24'h00_0000, sreg_reg};
            `CAE_ADDR_PC: rd_mux = {16'h0000, pc_reg};
            `CAE_ADDR_SP: rd_mux = {{(32-STK_AW){1'b0}}, sp_reg};
            `CAE_ADDR_TOS: rd_mux = {16'h0000, stk_reg[sp_reg - 1'b1]};
            default: rd_mux = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         wait_reg <= 1'b1;
      end else if (!wait_reg) begin
         wait_reg <= 1'b1;
      end else if (accept) begin
         wait_reg <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rdata_reg <= 32'h0000_0000;
      end else if (accept && avs_read_in) begin
         rdata_reg <= rd_mux;
      end
   end

   assign avs_waitrequest_out = wait_reg;
   assign avs_readdata_out = rdata_reg;

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   function automatic logic [1:0] cyc_of(cae_op_t op);
      case (op)
         CAE_OP_WORD_PLUS_IMMEDIATE, CAE_OP_WORD_MINUS_IMMEDIATE: cyc_of = `CAE_CYC_WORD;
         CAE_OP_PRODUCT_UNSIGNED, CAE_OP_PRODUCT_SIGNED, CAE_OP_PRODUCT_MIXED_SIGN,
         CAE_OP_FRACTION_PRODUCT_UNSIGNED, CAE_OP_FRACTION_PRODUCT_SIGNED,
         CAE_OP_FRACTION_PRODUCT_MIXED: cyc_of = `CAE_CYC_PROD;
         CAE_OP_POINTER_JUMP: cyc_of = `CAE_CYC_JUMP;
         CAE_OP_POINTER_CALL: cyc_of = `CAE_CYC_CALL;
         default: cyc_of = `CAE_CYC_ALU;
      endcase
   endfunction : cyc_of

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_reg <= CAE_ST_IDLE;
         cnt_reg <= 2'h0;
         ins_reg <= '0;
      end else begin
         case (state_reg)
            CAE_ST_IDLE: begin
               if (launch) begin
                  state_reg <= CAE_ST_RUN;
                  // Fields sit on byte lanes with gaps, so pick each one out
                  ins_reg <= cae_cmd_t'({avs_writedata_in[`CAE_CMD_OP_LSB +: 5],
                     avs_writedata_in[`CAE_CMD_DST_LSB +: 5], avs_writedata_in[`CAE_CMD_SRC_LSB +: 5],
                     avs_writedata_in[`CAE_CMD_IMM_LSB +: 8]});
                  cnt_reg <= cyc_of(cae_op_t'(avs_writedata_in[28:24]));
               end
            end
            CAE_ST_RUN: begin
               cnt_reg <= cnt_reg - 2'h1;
               if (commit) begin
                  state_reg <= CAE_ST_IDLE;
               end
            end
            default: state_reg <= CAE_ST_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Datapath
   // ------------------------------------------------------------
   logic [7:0] a;
   logic [7:0] b;
   logic cin;
   logic [8:0] sum9;
   logic [8:0] dif9;
   logic [4:0] hsum;
   logic [4:0] hdif;
   logic [4:0] wlo;
   logic [15:0] w;
   logic [15:0] wr;
   logic [17:0] p18;
   logic [15:0] prod;
   logic [7:0] r8;
   logic [15:0] r16;
   logic [7:0] fl;
   logic [4:0] wa;
   logic [4:0] wb;
   logic wa_en;
   logic wb_en;
   logic sgn_a;
   logic sgn_b;
   logic frac;
   logic [15:0] pc_nx;
   logic push;

   always_comb begin
      a = rf_reg[ins_reg.dst];
      b = rf_reg[ins_reg.src];
      case (ins_reg.op)
         CAE_OP_DIFFERENCE_IMMEDIATE, CAE_OP_DIFFERENCE_IMMEDIATE_BORROW, CAE_OP_CONJ_IMM,
         CAE_OP_DISJ_IMM, CAE_OP_MASK_SET_BITS: b = ins_reg.imm;
         CAE_OP_MASK_CLEAR_BITS: b = ~ins_reg.imm;
         CAE_OP_PLUS_ONE, CAE_OP_MINUS_ONE: b = 8'h01;
         CAE_OP_SELF_CHECK_FLAGS: b = a;
         default: b = rf_reg[ins_reg.src];
      endcase
      cin = (ins_reg.op == CAE_OP_SUM_CARRY || ins_reg.op == CAE_OP_DIFFERENCE_WITH_BORROW ||
             ins_reg.op == CAE_OP_DIFFERENCE_IMMEDIATE_BORROW) && sreg_reg[`CAE_FLG_C];
      sum9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      dif9 = {1'b0, a} - {1'b0, b} - {8'h00, cin};
      hsum = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      hdif = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
   end

   // Pair and product arithmetic
   always_comb begin
      wlo = {ins_reg.dst[4:1], 1'b0};
      w = {rf_reg[{ins_reg.dst[4:1], 1'b1}], rf_reg[wlo]};
      if (ins_reg.op == CAE_OP_WORD_MINUS_IMMEDIATE) begin
         wr = w - {10'h000, ins_reg.imm[5:0]};
      end else begin
         wr = w + {10'h000, ins_reg.imm[5:0]};
      end
      sgn_a = ins_reg.op inside {CAE_OP_PRODUCT_SIGNED, CAE_OP_PRODUCT_MIXED_SIGN,
                                 CAE_OP_FRACTION_PRODUCT_SIGNED, CAE_OP_FRACTION_PRODUCT_MIXED};
      sgn_b = ins_reg.op inside {CAE_OP_PRODUCT_SIGNED, CAE_OP_FRACTION_PRODUCT_SIGNED};
      frac = ins_reg.op inside {CAE_OP_FRACTION_PRODUCT_UNSIGNED,
                                CAE_OP_FRACTION_PRODUCT_SIGNED, CAE_OP_FRACTION_PRODUCT_MIXED};
      p18 = 18'($signed({sgn_a & a[7], a}) * $signed({sgn_b & b[7], b}));
      prod = frac ? {p18[14:0], 1'b0} : p18[15:0];
   end

   always_comb begin
      r8 = 8'h00;
      r16 = 16'h0000;
      fl = sreg_reg;
      wa = ins_reg.dst;
      wb = ins_reg.dst;
      wa_en = 1'b0;
      wb_en = 1'b0;
      pc_nx = pc_reg + 16'h0001;
      push = 1'b0;
      case (ins_reg.op)
         CAE_OP_SUM, CAE_OP_SUM_CARRY: begin
            r8 = sum9[7:0];
            wa_en = 1'b1;
            fl[`CAE_FLG_C] = sum9[8];
            fl[`CAE_FLG_H] = hsum[4];
            fl[`CAE_FLG_V] = (a[7] & b[7] & ~r8[7]) | (~a[7] & ~b[7] & r8[7]);
         end
         CAE_OP_DIFF, CAE_OP_DIFFERENCE_WITH_BORROW, CAE_OP_DIFFERENCE_IMMEDIATE,
         CAE_OP_DIFFERENCE_IMMEDIATE_BORROW: begin
            r8 = dif9[7:0];
            wa_en = 1'b1;
            fl[`CAE_FLG_C] = dif9[8];
            fl[`CAE_FLG_H] = hdif[4];
            fl[`CAE_FLG_V] = (a[7] & ~b[7] & ~r8[7]) | (~a[7] & b[7] & r8[7]);
         end
         CAE_OP_CONJ, CAE_OP_CONJ_IMM, CAE_OP_MASK_CLEAR_BITS, CAE_OP_SELF_CHECK_FLAGS: begin
            r8 = a & b;
            wa_en = 1'b1;
            fl[`CAE_FLG_V] = 1'b0;
         end
         CAE_OP_DISJ, CAE_OP_DISJ_IMM, CAE_OP_MASK_SET_BITS: begin
            r8 = a | b;
            wa_en = 1'b1;
            fl[`CAE_FLG_V] = 1'b0;
         end
         CAE_OP_EXCLUSIVE_DISJUNCTION: begin
            r8 = a ^ b;
            wa_en = 1'b1;
            fl[`CAE_FLG_V] = 1'b0;
         end
         CAE_OP_PLUS_ONE: begin
            r8 = sum9[7:0];
            wa_en = 1'b1;
            fl[`CAE_FLG_V] = r8 == 8'h80;
         end
         CAE_OP_MINUS_ONE: begin
            r8 = dif9[7:0];
            wa_en = 1'b1;
            fl[`CAE_FLG_V] = r8 == 8'h7F;
         end
         CAE_OP_WORD_PLUS_IMMEDIATE, CAE_OP_WORD_MINUS_IMMEDIATE: begin
            r16 = wr;
            wa = wlo;
            wb = {ins_reg.dst[4:1], 1'b1};
            wa_en = 1'b1;
            wb_en = 1'b1;
            fl[`CAE_FLG_N] = wr[15];
            fl[`CAE_FLG_Z] = wr == 16'h0000;
            if (ins_reg.op == CAE_OP_WORD_PLUS_IMMEDIATE) begin
               fl[`CAE_FLG_V] = ~w[15] & wr[15];
               fl[`CAE_FLG_C] = ~wr[15] & w[15];
            end else begin
               fl[`CAE_FLG_V] = w[15] & ~wr[15];
               fl[`CAE_FLG_C] = wr[15] & ~w[15];
            end
            fl[`CAE_FLG_S] = wr[15] ^ fl[`CAE_FLG_V];
         end
         CAE_OP_PRODUCT_UNSIGNED, CAE_OP_PRODUCT_SIGNED, CAE_OP_PRODUCT_MIXED_SIGN,
         CAE_OP_FRACTION_PRODUCT_UNSIGNED, CAE_OP_FRACTION_PRODUCT_SIGNED,
         CAE_OP_FRACTION_PRODUCT_MIXED: begin
            r16 = prod;
            wa = `CAE_PROD_LO;
            wb = `CAE_PROD_HI;
            wa_en = 1'b1;
            wb_en = 1'b1;
            // Carry is the top bit before the fractional shift
            fl[`CAE_FLG_C] = p18[15];
            fl[`CAE_FLG_Z] = prod == 16'h0000;
         end
         CAE_OP_POINTER_JUMP: begin
            pc_nx = {rf_reg[`CAE_PTR_HI], rf_reg[`CAE_PTR_LO]};
         end
         CAE_OP_POINTER_CALL: begin
            pc_nx = {rf_reg[`CAE_PTR_HI], rf_reg[`CAE_PTR_LO]};
            push = 1'b1;
         end
         default: begin
            wa_en = 1'b0;
         end
      endcase
      if (wa_en && !wb_en) begin
         fl[`CAE_FLG_Z] = r8 == 8'h00;
         fl[`CAE_FLG_N] = r8[7];
         // Borrow forms chain zero across bytes
         if (ins_reg.op inside {CAE_OP_DIFFERENCE_WITH_BORROW,
                                CAE_OP_DIFFERENCE_IMMEDIATE_BORROW}) begin
            fl[`CAE_FLG_Z] = (r8 == 8'h00) & sreg_reg[`CAE_FLG_Z];
         end
      end
      if (wb_en) begin
         r8 = r16[7:0];
      end
   end

   // ------------------------------------------------------------
   // Architectural state
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         for (int i = 0; i < 32; i++) begin
            rf_reg[i] <= 8'h00;
         end
      end else if (commit) begin
         if (wa_en) begin
            rf_reg[wa] <= r8;
         end
         if (wb_en) begin
            rf_reg[wb] <= r16[15:8];
         end
      end else if (wr_fire && rf_hit && avs_byteenable_in[0]) begin
         rf_reg[rf_idx] <= avs_writedata_in[7:0];
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         sreg_reg <= `CAE_SREG_RST;
      end else if (commit) begin
         sreg_reg <= fl;
      end else if (wr_fire && avs_address_in == `CAE_ADDR_SREG && avs_byteenable_in[0]) begin
         sreg_reg <= avs_writedata_in[7:0];
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         pc_reg <= `CAE_PC_RST;
      end else if (commit) begin
         pc_reg <= pc_nx;
      end else if (wr_fire && avs_address_in == `CAE_ADDR_PC) begin
         if (avs_byteenable_in[0]) begin
            pc_reg[7:0] <= avs_writedata_in[7:0];
         end
         if (avs_byteenable_in[1]) begin
            pc_reg[15:8] <= avs_writedata_in[15:8];
         end
      end
   end

   // Return stack wraps silently when over-filled
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         sp_reg <= '0;
      end else if (commit && push) begin
         sp_reg <= sp_reg + 1'b1;
      end else if (wr_fire && avs_address_in == `CAE_ADDR_SP && avs_byteenable_in[0]) begin
         sp_reg <= avs_writedata_in[STK_AW-1:0];
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (commit && push) begin
         stk_reg[sp_reg] <= pc_reg + 16'h0001;
      end
   end

endmodule : cae_exec

// file: tb/cae_exec_asserts.sv
/*
 * Bus handshake and instruction latency checks for cae_exec.
 * Assumes one clock domain and the port names of cae_exec; bound below.
 */
`timescale 1ns/100ps
`include "cae_defs.svh"

module cae_exec_asserts
   import cae_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   input wire logic [7:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic avs_waitrequest_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rst_b_in);

   // ------------------------------------------------------------
   // Bus handshake
   // ------------------------------------------------------------
   a_wait_one_cycle: assert property ($fell(avs_waitrequest_out) |=> avs_waitrequest_out)
      else $error("waitrequest low for more than one cycle");
   a_read_prompt: assert property ((avs_read_in && avs_waitrequest_out)
      |=> !avs_waitrequest_out)
      else $error("read not answered in the next cycle");
   a_idle_waits: assert property ((!avs_read_in && !avs_write_in) |=> avs_waitrequest_out)
      else $error("answer given without a request");
   a_rdata_holds: assert property (!(avs_read_in && avs_waitrequest_out)
      |=> $stable(avs_readdata_out))
      else $error("read data changed without a read");
   a_write_bound: assert property ((avs_write_in && avs_waitrequest_out)
      |-> ##[1:6] !avs_waitrequest_out)
      else $error("write stalled too long");

   // ------------------------------------------------------------
   // Instruction latency
   // ------------------------------------------------------------
   sequence cmd_acc(logic [4:0] op);
      avs_write_in && !avs_waitrequest_out && avs_address_in == `CAE_ADDR_CMD
         && avs_writedata_in[28:24] == op;
   endsequence
   // Commit edge may count as idle, so only the cycles before it are barred
   sequence no_accept;
      !(avs_write_in && !avs_waitrequest_out);
   endsequence

   a_word_latency: assert property (cmd_acc(CAE_OP_WORD_MINUS_IMMEDIATE)
      |=> no_accept [*2])
      else $error("word operation finished early");
   a_prod_latency: assert property (cmd_acc(CAE_OP_PRODUCT_SIGNED) |=> no_accept [*2])
      else $error("multiply finished early");
   a_jump_latency: assert property (cmd_acc(CAE_OP_POINTER_JUMP) |=> no_accept [*2])
      else $error("pointer jump finished early");
   a_call_latency: assert property (cmd_acc(CAE_OP_POINTER_CALL) |=> no_accept [*3])
      else $error("pointer call finished early");
endmodule : cae_exec_asserts

bind cae_exec cae_exec_asserts u_chk (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
   .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
   .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
   .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out));

// file: tb/cae_exec_tb.sv
/*
 * Self-checking bench for cae_exec: arithmetic, logic, multiply and
 * pointer branch commands issued and judged over Avalon-MM.
 * Assumes the checker is bound in by its own file.
 */
`timescale 1ns/100ps
`include "cae_defs.svh"

module cae_exec_tb;
   import cae_pkg::*;
   logic sys_clk;
   logic rst_b;
   logic [7:0] addr;
   logic rd;
   logic wr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic waitreq;
   int mismatches;
   int n_compared;

   cae_exec uut (.sys_clk_in(sys_clk), .rst_b_in(rst_b), .avs_address_in(addr),
      .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
      .avs_byteenable_in(4'hF), .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq));

   // ------------------------------------------------------------
   // Bus and check tasks
   // ------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // Waitrequest is sampled before this edge's updates land
   task automatic bus_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] v);
      int n;
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      rd <= !w;
      wr <= w;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (waitreq !== 1'b0 && n < 40);
      v = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      if (n >= 40) chk("bus answer", 32'h1, 32'h0);
   endtask : bus_xfer

   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] v;
      bus_xfer(1'b1, a, d, v);
   endtask : bus_wr

   task automatic chk_rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] v;
      bus_xfer(1'b0, a, 32'h0, v);
      chk(nm, v, exp);
   endtask : chk_rd

   function automatic logic [7:0] ra(input logic [4:0] i);
      return 8'h80 + {1'b0, i, 2'b00};
   endfunction : ra

   task automatic run(input cae_op_t op, input logic [4:0] d, input logic [4:0] s,
      input logic [7:0] k);
      logic [31:0] st;
      int n;
      bus_wr(`CAE_ADDR_CMD, {3'h0, op, 3'h0, d, 3'h0, s, k});
      n = 0;
      do begin
         bus_xfer(1'b0, `CAE_ADDR_STATUS, 32'h0, st);
         n++;
      end while (st[0] !== 1'b0 && n < 10);
      if (n >= 10) chk("busy clear", st, 32'h0);
   endtask : run

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      chk_rd("sreg reset", `CAE_ADDR_SREG, 32'h0);
      chk_rd("pc reset", `CAE_ADDR_PC, 32'h0);
      chk_rd("r31 reset", ra(5'h1F), 32'h0);
      bus_wr(8'h40, 32'hFF);
      chk_rd("unmapped", 8'h40, 32'h0);
      $display("test reset done");
   endtask : t_reset

   task automatic t_arith();
      bus_wr(ra(5'h02), 32'h78);
      bus_wr(ra(5'h03), 32'h08);
      bus_wr(ra(5'h04), 32'h00);
      bus_wr(ra(5'h05), 32'h01);
      bus_wr(`CAE_ADDR_SREG, 32'h0);
      run(CAE_OP_SUM, 5'h02, 5'h03, 8'h00);
      chk_rd("sum", ra(5'h02), 32'h80);
      chk_rd("sum flags", `CAE_ADDR_SREG, 32'h2C);
      run(CAE_OP_DIFF, 5'h04, 5'h05, 8'h00);
      chk_rd("diff", ra(5'h04), 32'hFF);
      chk_rd("diff flags", `CAE_ADDR_SREG, 32'h25);
      run(CAE_OP_SUM_CARRY, 5'h02, 5'h03, 8'h00);
      chk_rd("sum carry", ra(5'h02), 32'h89);
      chk_rd("sum carry flags", `CAE_ADDR_SREG, 32'h04);
      $display("test arith done");
   endtask : t_arith

   task automatic t_borrow();
      bus_wr(`CAE_ADDR_SREG, 32'h03);
      bus_wr(ra(5'h06), 32'h10);
      bus_wr(ra(5'h07), 32'h0F);
      run(CAE_OP_DIFFERENCE_WITH_BORROW, 5'h06, 5'h07, 8'h00);
      chk_rd("borrow", ra(5'h06), 32'h00);
      chk_rd("borrow flags", `CAE_ADDR_SREG, 32'h22);
      run(CAE_OP_DIFFERENCE_IMMEDIATE_BORROW, 5'h06, 5'h00, 8'h01);
      chk_rd("imm borrow", ra(5'h06), 32'hFF);
      chk_rd("imm borrow flags", `CAE_ADDR_SREG, 32'h25);
      run(CAE_OP_DIFFERENCE_IMMEDIATE, 5'h06, 5'h00, 8'h7F);
      chk_rd("imm diff", ra(5'h06), 32'h80);
      chk_rd("imm diff flags", `CAE_ADDR_SREG, 32'h04);
      $display("test borrow done");
   endtask : t_borrow

   task automatic t_word();
      bus_wr(`CAE_ADDR_SREG, 32'h00);
      bus_wr(ra(5'h18), 32'hFF);
      bus_wr(ra(5'h19), 32'h7F);
      run(CAE_OP_WORD_PLUS_IMMEDIATE, 5'h18, 5'h00, 8'h01);
      chk_rd("word plus lo", ra(5'h18), 32'h00);
      chk_rd("word plus hi", ra(5'h19), 32'h80);
      chk_rd("word plus flags", `CAE_ADDR_SREG, 32'h0C);
      run(CAE_OP_WORD_MINUS_IMMEDIATE, 5'h18, 5'h00, 8'h01);
      chk_rd("word minus hi", ra(5'h19), 32'h7F);
      chk_rd("word minus flags", `CAE_ADDR_SREG, 32'h18);
      $display("test word done");
   endtask : t_word

   task automatic t_logic();
      cae_op_t ops[10] = '{CAE_OP_CONJ, CAE_OP_CONJ_IMM, CAE_OP_DISJ, CAE_OP_DISJ_IMM,
         CAE_OP_EXCLUSIVE_DISJUNCTION, CAE_OP_MASK_SET_BITS, CAE_OP_MASK_CLEAR_BITS,
         CAE_OP_PLUS_ONE, CAE_OP_MINUS_ONE, CAE_OP_SELF_CHECK_FLAGS};
      logic [7:0] av[10] = '{8'hC3, 8'hA5, 8'hA5, 8'h00, 8'h3C, 8'h80, 8'h0F, 8'h7F, 8'h80, 8'h00};
      logic [7:0] rv[10] = '{8'h00, 8'h05, 8'hBD, 8'h0F, 8'h00, 8'h8F, 8'h00, 8'h80, 8'h7F, 8'h00};
      logic [7:0] fv[10] = '{8'h23, 8'h21, 8'h25, 8'h21, 8'h23, 8'h25, 8'h23, 8'h2D, 8'h29, 8'h23};
      bus_wr(ra(5'h09), 32'h3C);
      // Carry and half carry preset to show they survive
      for (int i = 0; i < 10; i++) begin
         bus_wr(ra(5'h08), {24'h0, av[i]});
         bus_wr(`CAE_ADDR_SREG, 32'h29);
         run(ops[i], 5'h08, 5'h09, 8'h0F);
         chk_rd(ops[i].name(), ra(5'h08), {24'h0, rv[i]});
         chk_rd("logic flags", `CAE_ADDR_SREG, {24'h0, fv[i]});
      end
      $display("test logic done");
   endtask : t_logic

   task automatic t_prod();
      cae_op_t ops[6] = '{CAE_OP_PRODUCT_UNSIGNED, CAE_OP_PRODUCT_SIGNED,
         CAE_OP_PRODUCT_MIXED_SIGN, CAE_OP_FRACTION_PRODUCT_UNSIGNED,
         CAE_OP_FRACTION_PRODUCT_SIGNED, CAE_OP_FRACTION_PRODUCT_MIXED};
      logic [15:0] pv[6] = '{16'h02FA, 16'hFFFA, 16'hFFFA, 16'h05F4, 16'hFFF4, 16'hFFF4};
      logic cv[6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
      bus_wr(ra(5'h10), 32'hFE);
      bus_wr(ra(5'h11), 32'h03);
      for (int i = 0; i < 6; i++) begin
         bus_wr(`CAE_ADDR_SREG, 32'h00);
         run(ops[i], 5'h10, 5'h11, 8'h00);
         chk_rd(ops[i].name(), ra(5'h00), {24'h0, pv[i][7:0]});
         chk_rd("product hi", ra(5'h01), {24'h0, pv[i][15:8]});
         chk_rd("product flags", `CAE_ADDR_SREG, {31'h0, cv[i]});
      end
      $display("test multiply done");
   endtask : t_prod

   task automatic t_ptr();
      bus_wr(ra(5'h1E), 32'h34);
      bus_wr(ra(5'h1F), 32'h12);
      bus_wr(`CAE_ADDR_SREG, 32'h3F);
      bus_wr(`CAE_ADDR_PC, 32'h0100);
      run(CAE_OP_POINTER_JUMP, 5'h00, 5'h00, 8'h00);
      chk_rd("jump pc", `CAE_ADDR_PC, 32'h1234);
      chk_rd("jump flags", `CAE_ADDR_SREG, 32'h3F);
      bus_wr(`CAE_ADDR_PC, 32'h0200);
      // Next write right behind the call must stall until it commits
      bus_wr(`CAE_ADDR_CMD, {3'h0, CAE_OP_POINTER_CALL, 24'h0});
      bus_wr(`CAE_ADDR_SREG, 32'h3F);
      chk_rd("call pc", `CAE_ADDR_PC, 32'h1234);
      chk_rd("call sp", `CAE_ADDR_SP, 32'h01);
      chk_rd("call return", `CAE_ADDR_TOS, 32'h0201);
      $display("test pointer done");
   endtask : t_ptr

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : test_done

   // ------------------------------------------------------------
   // Clock, watchdog and main sequence
   // ------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   initial begin
      repeat (20000) @(posedge sys_clk);
      mismatches++;
      test_done();
   end

   initial begin
      rst_b = 1'b0;
      addr = 8'h00;
      rd = 1'b0;
      wr = 1'b0;
      wdata = 32'h0;
      mismatches = 0;
      n_compared = 0;
      repeat (3) @(posedge sys_clk);
      rst_b <= 1'b1;
      t_reset();
      t_arith();
      t_borrow();
      t_word();
      t_logic();
      t_prod();
      t_ptr();
      test_done();
   end
endmodule : cae_exec_tb
